/* File: core/fma_pkg.sv */
package fma_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned SAMPLE_TIME_NS  = 500000;     // Flow sample period
  localparam int unsigned TEMP_TIME_NS    = 11111111;   // Temperature period at 90 Hz
  localparam int unsigned FIRST_TIME_NS   = 12000000;   // Start to first result
  localparam int unsigned READY_TYP_NS    = 16000000;   // Typical ready time
  localparam int unsigned READY_MAX_NS    = 20000000;   // Longest ready time
  localparam int unsigned MEAN_TIME_MS    = 64;         // Arithmetic-mean window
  localparam int unsigned SAMPLE_TIME_US  = 500;

  // Sample and temperature periods are typical figures, rounded to nearest
  localparam int unsigned SAMPLE_CYC    = (SAMPLE_TIME_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned TEMP_CYC      = (TEMP_TIME_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned FIRST_CYC     = (FIRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_TYP_CYC = (READY_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_MAX_CYC = READY_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned MEAN_SAMPLES  = MEAN_TIME_MS * 1000 / SAMPLE_TIME_US;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned FLOW_W   = 16;
  localparam int unsigned N_W      = 8;
  localparam int unsigned ACC_W    = 23;
  localparam int unsigned FRAC_W   = 16;
  localparam int unsigned SMOOTH_W = 32;
  localparam int unsigned CNT_W    = 24;
  localparam int unsigned DIV_STEP_W = 5;

  // ---------------------------------------------------------------
  // Averaging configuration
  // ---------------------------------------------------------------
  localparam logic [N_W-1:0]    N_UNTIL_READ = 8'h00;
  localparam logic [N_W-1:0]    N_MAX        = 8'h80;
  localparam logic [N_W-1:0]    MEAN_CNT     = N_W'(MEAN_SAMPLES);
  // 0.02 in unsigned Q16, 1310.72 rounded
  localparam logic [11:0]       ALPHA_Q16    = 12'h51F;
  localparam logic [DIV_STEP_W-1:0] DIV_STEPS = 5'h17;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [FLOW_W-1:0] RST_WORD   = 16'h0000;
  localparam logic [ACC_W-1:0]  RST_ACC    = 23'h000000;
  localparam logic [N_W-1:0]    RST_N      = 8'h00;
  localparam logic [SMOOTH_W-1:0] RST_SMOOTH = 32'h00000000;
  localparam logic [CNT_W-1:0]  RST_CNT    = 24'h000000;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_INIT,
    ST_RUN
  } fma_state_t;

endpackage

/* File: core/fma_div_if.sv */
`timescale 1ns/100ps
interface fma_div_if;
  logic                        start;
  logic [fma_pkg::ACC_W-1:0]   dividend;
  logic [fma_pkg::N_W-1:0]     divisor;
  logic                        done;
  logic [fma_pkg::FLOW_W-1:0]  quotient;

  modport client (output start, output dividend, output divisor,
                  input done, input quotient);
  modport unit   (input start, input dividend, input divisor,
                  output done, output quotient);
endinterface

/* File: core/fma_divider.sv */
`timescale 1ns/100ps
module fma_divider (
  input wire logic   core_clk,   // System clock
  input wire logic   nrst,       // Async reset, active low
  fma_div_if.unit    div         // Divide request and result
);

  // ---------------------------------------------------------------
  // Restoring division, one quotient bit per cycle
  // ---------------------------------------------------------------
  logic [fma_pkg::ACC_W-1:0]      work;
  logic [fma_pkg::N_W:0]          rem;
  logic [fma_pkg::N_W-1:0]        dvs;
  logic [fma_pkg::DIV_STEP_W-1:0] steps;
  logic                           busy;
  logic                           doneQ;

  wire [fma_pkg::N_W:0] shifted = {rem[fma_pkg::N_W-1:0], work[fma_pkg::ACC_W-1]};
  wire                  fits    = shifted >= {1'b0, dvs};
  wire [fma_pkg::N_W:0] reduced = shifted - {1'b0, dvs};
  wire                  last    = steps == 5'h01;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      work  <= fma_pkg::RST_ACC;
      rem   <= 9'h000;
      dvs   <= fma_pkg::RST_N;
      steps <= 5'h00;
      busy  <= 1'b0;
    end else if (div.start) begin
      work  <= div.dividend;
      rem   <= 9'h000;
      dvs   <= div.divisor;
      steps <= fma_pkg::DIV_STEPS;
      busy  <= 1'b1;
    end else if (busy) begin
      work  <= {work[fma_pkg::ACC_W-2:0], fits};
      rem   <= fits ? reduced : shifted;
      steps <= steps - 5'h01;
      busy  <= !last;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      doneQ <= 1'b0;
    end else begin
      doneQ <= busy && last && !div.start;
    end
  end

  // Mean never exceeds one sample, so the low word holds it all
  assign div.quotient = work[fma_pkg::FLOW_W-1:0];
  assign div.done     = doneQ;

endmodule

/* File: core/fma_flow_avg.sv */
`timescale 1ns/100ps
module fma_flow_avg #(
  parameter int unsigned SAMPLE_CYC    = fma_pkg::SAMPLE_CYC,
  parameter int unsigned TEMP_CYC      = fma_pkg::TEMP_CYC,
  parameter int unsigned FIRST_CYC     = fma_pkg::FIRST_CYC,
  parameter int unsigned READY_TYP_CYC = fma_pkg::READY_TYP_CYC,
  parameter int unsigned READY_MAX_CYC = fma_pkg::READY_MAX_CYC
) (
  input  wire logic                       core_clk,        // System clock, 50 MHz
  input  wire logic                       nrst,            // Async reset, active low
  input  wire logic                       scl,             // Serial clock pin level
  input  wire logic                       startCmd,        // Start measurement pulse
  input  wire logic                       softResetCmd,    // Soft reset pulse
  input  wire logic                       wakeCmd,         // Sleep exit pulse
  input  wire logic                       avgCfgValid,     // Averaging config pulse
  input  wire logic [fma_pkg::N_W-1:0]    avgCfgN,         // Averaging argument N
  input  wire logic                       readReq,         // Host read header seen
  input  wire logic                       readDone,        // Readout completed pulse
  input  wire logic [fma_pkg::FLOW_W-1:0] flowIn,          // Raw flow from front end
  input  wire logic [fma_pkg::FLOW_W-1:0] tempIn,          // Raw temperature
  input  wire logic [fma_pkg::FLOW_W-1:0] statusIn,        // Status word
  output      logic                       commReady,       // Answers communication
  output      logic                       heaterOn,        // Heater enable
  output      logic                       sampleTick,      // Flow sample taken
  output      logic                       readAck,         // Acknowledge read header
  output      logic [fma_pkg::FLOW_W-1:0] flowOut,         // Reported flow
  output      logic [fma_pkg::FLOW_W-1:0] tempOut,         // Reported temperature
  output      logic [fma_pkg::FLOW_W-1:0] statusOut,       // Reported status
  output      logic                       reading_ready_n  // Reading ready, active low
);

  // ---------------------------------------------------------------
  // Count limits
  // ---------------------------------------------------------------
  localparam logic [fma_pkg::CNT_W-1:0] SAMPLE_LAST = (fma_pkg::CNT_W)'(SAMPLE_CYC - 1);
  localparam logic [fma_pkg::CNT_W-1:0] TEMP_LAST   = (fma_pkg::CNT_W)'(TEMP_CYC - 1);
  localparam logic [fma_pkg::CNT_W-1:0] FIRST_LAST  = (fma_pkg::CNT_W)'(FIRST_CYC - 1);
  localparam logic [fma_pkg::CNT_W-1:0] TYP_LAST    = (fma_pkg::CNT_W)'(READY_TYP_CYC - 1);
  localparam logic [fma_pkg::CNT_W-1:0] MAX_LAST    = (fma_pkg::CNT_W)'(READY_MAX_CYC - 1);

  fma_pkg::fma_state_t state;

  logic                          sclS1;
  logic                          sclS2;
  logic                          sclS3;
  logic                          sclLevel;
  logic [fma_pkg::CNT_W-1:0]     bootCnt;
  logic [fma_pkg::CNT_W-1:0]     sclHighCnt;
  logic [fma_pkg::CNT_W-1:0]     phaseCnt;
  logic [fma_pkg::CNT_W-1:0]     tempCnt;
  logic                          fixedMode;
  logic [fma_pkg::N_W-1:0]       avgN;
  logic [fma_pkg::ACC_W-1:0]     accSum;
  logic [fma_pkg::N_W-1:0]       accCnt;
  logic                          expPhase;
  logic                          divSeed;
  logic [fma_pkg::SMOOTH_W-1:0]  smooth;
  logic [fma_pkg::FLOW_W-1:0]    tempLatest;
  logic [fma_pkg::FLOW_W-1:0]    statusLatest;
  logic                          newData;
  logic                          irqLow;

  fma_div_if div ();

  fma_divider u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .div      (div)
  );

  // ---------------------------------------------------------------
  // Serial clock pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclS1    <= 1'b1;
      sclS2    <= 1'b1;
      sclS3    <= 1'b1;
      sclLevel <= 1'b1;
    end else begin
      sclS1 <= scl;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      if (sclS2 == sclS3) begin
        sclLevel <= sclS3;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencing decode
  // ---------------------------------------------------------------
  wire inBoot   = state == fma_pkg::ST_BOOT;
  wire inRun    = state == fma_pkg::ST_RUN;
  wire restart  = softResetCmd || wakeCmd;
  // Typical recovery only while the clock line idles high
  wire bootDone = (sclHighCnt >= TYP_LAST) || (bootCnt >= MAX_LAST);
  wire startOk  = startCmd && state == fma_pkg::ST_IDLE && !restart;
  wire initDone = state == fma_pkg::ST_INIT && phaseCnt == FIRST_LAST;
  wire cfgOk    = avgCfgValid && !inBoot && !restart && avgCfgN <= fma_pkg::N_MAX;
  wire readOk   = readDone && inRun && newData;

  assign sampleTick = inRun && phaseCnt == SAMPLE_LAST;
  wire   tempTick   = inRun && tempCnt == TEMP_LAST;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= fma_pkg::ST_BOOT;
    end else if (restart) begin
      state <= fma_pkg::ST_BOOT;
    end else begin
      unique case (state)
        fma_pkg::ST_BOOT: state <= bootDone ? fma_pkg::ST_IDLE : fma_pkg::ST_BOOT;
        fma_pkg::ST_IDLE: state <= startOk ? fma_pkg::ST_INIT : fma_pkg::ST_IDLE;
        fma_pkg::ST_INIT: state <= initDone ? fma_pkg::ST_RUN : fma_pkg::ST_INIT;
        fma_pkg::ST_RUN:  state <= fma_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bootCnt    <= fma_pkg::RST_CNT;
      sclHighCnt <= fma_pkg::RST_CNT;
    end else if (restart) begin
      bootCnt    <= fma_pkg::RST_CNT;
      sclHighCnt <= fma_pkg::RST_CNT;
    end else if (inBoot) begin
      bootCnt    <= bootCnt + 24'h000001;
      sclHighCnt <= sclHighCnt + {23'h000000, sclLevel};
    end
  end

  // Shared counter: init delay first, then the sample period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phaseCnt <= fma_pkg::RST_CNT;
      tempCnt  <= fma_pkg::RST_CNT;
    end else if (restart || startOk) begin
      phaseCnt <= fma_pkg::RST_CNT;
      tempCnt  <= fma_pkg::RST_CNT;
    end else if (initDone) begin
      phaseCnt <= SAMPLE_LAST;
      tempCnt  <= TEMP_LAST;
    end else begin
      phaseCnt <= (sampleTick || !(inRun || state == fma_pkg::ST_INIT)) ?
                  fma_pkg::RST_CNT : phaseCnt + 24'h000001;
      tempCnt  <= (tempTick || !inRun) ? fma_pkg::RST_CNT : tempCnt + 24'h000001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      heaterOn <= 1'b0;
    end else if (restart) begin
      heaterOn <= 1'b0;
    end else if (startOk) begin
      heaterOn <= 1'b1;
    end
  end

  assign commReady = !inBoot;

  // ---------------------------------------------------------------
  // Averaging configuration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fixedMode <= 1'b0;
      avgN      <= fma_pkg::RST_N;
    end else if (restart) begin
      fixedMode <= 1'b0;
      avgN      <= fma_pkg::RST_N;
    end else if (cfgOk) begin
      fixedMode <= avgCfgN != fma_pkg::N_UNTIL_READ;
      avgN      <= avgCfgN;
    end
  end

  // ---------------------------------------------------------------
  // Accumulation
  // ---------------------------------------------------------------
  // A sample in the readout cycle becomes the first of the new mean
  wire clearAcc = cfgOk || (readOk && !fixedMode);
  wire [fma_pkg::ACC_W-1:0] accBase = clearAcc ? fma_pkg::RST_ACC : accSum;
  wire [fma_pkg::N_W-1:0]   cntBase = clearAcc ? fma_pkg::RST_N : accCnt;
  wire                      expBase = !clearAcc && expPhase;
  wire [fma_pkg::N_W-1:0]   cntInc  = cntBase + 8'h01;
  wire [fma_pkg::ACC_W-1:0] accNext = accBase + {7'h00, flowIn};
  wire                      groupEnd = cntInc == avgN;
  wire                      expUpdate = sampleTick && !fixedMode && expBase;
  wire                      meanStart = sampleTick && !fixedMode && !expBase;
  wire                      fixedStart = sampleTick && fixedMode && groupEnd;

  assign div.start    = meanStart || fixedStart;
  assign div.dividend = accNext;
  // Divide by one passes the sample through untouched
  assign div.divisor  = fixedMode ? avgN : cntInc;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accSum   <= fma_pkg::RST_ACC;
      accCnt   <= fma_pkg::RST_N;
      expPhase <= 1'b0;
    end else if (restart) begin
      accSum   <= fma_pkg::RST_ACC;
      accCnt   <= fma_pkg::RST_N;
      expPhase <= 1'b0;
    end else if (fixedStart) begin
      accSum   <= fma_pkg::RST_ACC;
      accCnt   <= fma_pkg::RST_N;
      expPhase <= 1'b0;
    end else if (meanStart) begin
      accSum   <= accNext;
      accCnt   <= cntInc;
      expPhase <= cntInc == fma_pkg::MEAN_CNT;
    end else if (sampleTick && fixedMode) begin
      accSum   <= accNext;
      accCnt   <= cntInc;
      expPhase <= 1'b0;
    end else begin
      accSum   <= accBase;
      accCnt   <= cntBase;
      expPhase <= expBase;
    end
  end

  // ---------------------------------------------------------------
  // Exponential smoothing, Q16 fraction kept between samples
  // ---------------------------------------------------------------
  wire signed [32:0] expDelta = $signed({1'b0, flowIn, 16'h0000}) - $signed({1'b0, smooth});
  wire signed [44:0] expProd  = expDelta * $signed({1'b0, fma_pkg::ALPHA_Q16});
  wire signed [44:0] expSum   = $signed({13'h0000, smooth}) + (expProd >>> fma_pkg::FRAC_W);
  wire [fma_pkg::SMOOTH_W-1:0] nextSmooth = expSum[fma_pkg::SMOOTH_W-1:0];
  wire seedNow = div.done && divSeed && expPhase;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divSeed <= 1'b0;
    end else if (div.start) begin
      divSeed <= meanStart && cntInc == fma_pkg::MEAN_CNT;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      smooth <= fma_pkg::RST_SMOOTH;
    end else if (seedNow) begin
      smooth <= {div.quotient, 16'h0000};
    end else if (expUpdate) begin
      smooth <= nextSmooth;
    end
  end

  // ---------------------------------------------------------------
  // Result bundle
  // ---------------------------------------------------------------
  wire publish = div.done || expUpdate;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tempLatest   <= fma_pkg::RST_WORD;
      statusLatest <= fma_pkg::RST_WORD;
    end else begin
      if (tempTick) begin
        tempLatest <= tempIn;
      end
      if (sampleTick) begin
        statusLatest <= statusIn;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flowOut   <= fma_pkg::RST_WORD;
      tempOut   <= fma_pkg::RST_WORD;
      statusOut <= fma_pkg::RST_WORD;
    end else if (publish && inRun && !restart) begin
      flowOut   <= expUpdate ? nextSmooth[31:16] : div.quotient;
      tempOut   <= tempLatest;
      statusOut <= sampleTick ? statusIn : statusLatest;
    end
  end

  // ---------------------------------------------------------------
  // Ready signalling; a new reading beats a same-cycle readout
  // ---------------------------------------------------------------
  wire fresh = publish && inRun && !restart;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      newData <= 1'b0;
    end else if (restart) begin
      newData <= 1'b0;
    end else if (fresh) begin
      newData <= 1'b1;
    end else if (readOk) begin
      newData <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqLow <= 1'b1;
    end else if (restart) begin
      irqLow <= 1'b1;
    end else if (fresh) begin
      irqLow <= 1'b1;
    end else if (startOk || readOk) begin
      irqLow <= 1'b0;
    end
  end

  assign reading_ready_n = !irqLow;
  assign readAck         = readReq && inRun && newData;

endmodule

/* File: bench/fma_flow_avg_properties.sv */
`timescale 1ns/100ps
module fma_flow_avg_properties #(
  parameter int unsigned SAMPLE_CYC    = 40,
  parameter int unsigned FIRST_CYC     = 100,
  parameter int unsigned READY_MAX_CYC = 80
) (
  input wire logic core_clk,        // Clock
  input wire logic nrst,            // Reset
  input wire logic startCmd,        // Start
  input wire logic softResetCmd,    // Soft reset
  input wire logic wakeCmd,         // Wake
  input wire logic readReq,         // Read header
  input wire logic readDone,        // Readout done
  input wire logic commReady,       // Answers bus
  input wire logic heaterOn,        // Heater
  input wire logic sampleTick,      // Sample taken
  input wire logic readAck,         // Header ack
  input wire logic reading_ready_n  // Ready line
);
  logic [15:0] gap;
  logic [15:0] heat;
  logic [15:0] boot;
  logic        seen;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap  <= 16'h0000;
      heat <= 16'h0000;
      boot <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap  <= sampleTick ? 16'h0000 : gap + 16'h0001;
      heat <= heaterOn ? heat + 16'h0001 : 16'h0000;
      boot <= commReady ? 16'h0000 : boot + 16'h0001;
      seen <= heaterOn & (seen | sampleTick);
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_ack_has_data: assert property (readAck |-> readReq && !reading_ready_n)
    else $error("ack without reading");
  a_boot_heat_off: assert property (!commReady |-> !heaterOn)
    else $error("heater on before ready");
  a_boot_ready_low: assert property (!commReady |-> !reading_ready_n)
    else $error("ready line high in boot");
  a_start_effect: assert property (
    startCmd && commReady && !heaterOn && !softResetCmd && !wakeCmd
    |=> heaterOn && reading_ready_n)
    else $error("start not taken");
  a_tick_period: assert property (sampleTick && seen |-> gap == SAMPLE_CYC - 1)
    else $error("sample period wrong");
  a_first_result: assert property (
    sampleTick && !seen |-> heat + 3 >= FIRST_CYC && heat <= FIRST_CYC + 1)
    else $error("first sample late");
  a_ready_bound: assert property (!commReady |-> boot < READY_MAX_CYC + 3)
    else $error("recovery too long");
  // A divided result lands a fixed divide latency after its sample
  a_publish_delay: assert property (
    $fell(reading_ready_n) && heaterOn
    |-> $past(sampleTick, 24) || $past(sampleTick, 25) || $past(sampleTick, 26))
    else $error("ready line fell off schedule");
  a_read_clears: assert property (
    readDone && !reading_ready_n && heaterOn && !softResetCmd && !wakeCmd
    |=> reading_ready_n || $past(sampleTick, 25) || $past(sampleTick, 26))
    else $error("ready line not cleared");
  c_tick: cover property (sampleTick && seen);
  c_ack: cover property (readAck);
  c_heat: cover property ($rose(heaterOn));
endmodule

/* File: bench/fma_host_model.sv */
`timescale 1ns/100ps
module fma_host_model (
  input  wire logic                       core_clk,        // Clock
  input  wire logic                       nrst,            // Reset
  input  wire logic                       en,              // Poll enable
  input  wire logic                       reading_ready_n, // Ready line
  input  wire logic                       readAck,         // Header ack
  input  wire logic [fma_pkg::FLOW_W-1:0] flowOut,         // Flow result
  output      logic                       readReq,         // Read header
  output      logic                       readDone,        // Readout done
  output      logic [fma_pkg::FLOW_W-1:0] lastFlow,        // Last flow read
  output      logic [15:0]                readCount,       // Readouts
  output      logic [15:0]                nackCount        // Refused headers
);
  logic [1:0] phase;
  // Polls on the ready line, so reads stay well under the mean window
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readReq   <= 1'b0;
      readDone  <= 1'b0;
      phase     <= 2'h0;
      lastFlow  <= 16'h0000;
      readCount <= 16'h0000;
      nackCount <= 16'h0000;
    end else begin
      readDone <= phase == 2'h1 && readAck;
      case (phase)
        2'h0: if (en && !reading_ready_n) begin
          readReq <= 1'b1;
          phase   <= 2'h1;
        end
        2'h1: begin
          if (readAck) begin
            lastFlow  <= flowOut;
            readCount <= readCount + 16'h0001;
          end else begin
            nackCount <= nackCount + 16'h0001;
          end
          readReq <= 1'b0;
          phase   <= 2'h2;
        end
        default: phase <= 2'h0;
      endcase
    end
  end
endmodule

/* File: bench/fma_flow_avg_test.sv */
`timescale 1ns/100ps
module fma_flow_avg_test;
  logic        core_clk = 1'b0, nrst = 1'b0, scl = 1'b1, startCmd = 1'b0, en = 1'b1;
  logic        softResetCmd = 1'b0, wakeCmd = 1'b0, avgCfgValid = 1'b0;
  logic [7:0]  avgCfgN = 8'h00;
  logic [15:0] flowIn = 16'h0100, tickCount = 16'h0000, k, r;
  logic [15:0] tempIn = 16'h1234, statusIn = 16'h00A5;
  logic [15:0] flowOut, tempOut, statusOut, lastFlow, readCount, nackCount;
  logic        readReq, readDone, commReady, heaterOn, sampleTick, readAck, reading_ready_n;
  int          err_total = 0, total_checks = 0, cyc = 0, n;
  fma_flow_avg #(.SAMPLE_CYC(40), .TEMP_CYC(400), .FIRST_CYC(100), .READY_TYP_CYC(60),
    .READY_MAX_CYC(80)) dut (.core_clk, .nrst, .scl, .startCmd, .softResetCmd, .wakeCmd,
    .avgCfgValid, .avgCfgN, .readReq, .readDone, .flowIn, .tempIn,
    .statusIn, .commReady, .heaterOn, .sampleTick, .readAck, .flowOut, .tempOut,
    .statusOut, .reading_ready_n);
  fma_host_model host (.core_clk, .nrst, .en, .reading_ready_n, .readAck, .flowOut, .readReq,
    .readDone, .lastFlow, .readCount, .nackCount);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Ramp of 4 per sample makes every mean an exact integer
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
    // One gas for the whole run, so flow never needs a settling wait
    if (sampleTick) begin
      flowIn    <= flowIn + 16'h0004;
      tempIn    <= tempIn + 16'h0001;
      statusIn  <= statusIn + 16'h0001;
      tickCount <= tickCount + 16'h0001;
    end
  end
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t result mismatch", $time);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (commReady !== 1'b1) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  task automatic wait_ticks(input logic [15:0] t);
    while (tickCount != t) @(negedge core_clk);
    repeat (30) @(negedge core_clk);
  endtask
  // Config kept clear of a sample edge so the group start is known
  task automatic cfg(input logic [7:0] v);
    @(posedge core_clk iff sampleTick);
    repeat (5) @(posedge core_clk);
    avgCfgValid <= 1'b1;
    avgCfgN     <= v;
    @(posedge core_clk) avgCfgValid <= 1'b0;
    @(negedge core_clk) k = tickCount;
  endtask
  task automatic t_boot;
    chk(reading_ready_n === 1'b0 && heaterOn === 1'b0);
    wait_ready(n);
    chk(n <= 63);
    chk(readCount === 16'h0000 && nackCount !== 16'h0000);
  endtask
  task automatic t_until;
    @(posedge core_clk) startCmd <= 1'b1;
    @(posedge core_clk) startCmd <= 1'b0;
    @(negedge core_clk);
    chk(heaterOn === 1'b1 && reading_ready_n === 1'b1);
    wait_ticks(16'h0004);
    @(posedge core_clk) en <= 1'b1;
    while (readCount != 16'h0001) @(negedge core_clk);
    @(posedge core_clk) en <= 1'b0;
    chk(lastFlow === 16'h0106);
    wait_ticks(16'h0006);
    @(posedge core_clk) en <= 1'b1;
    while (readCount != 16'h0002) @(negedge core_clk);
    chk(lastFlow === 16'h0112);
  endtask
  // Temperature ticks land on every tenth sample, the first one included
  task automatic t_fixed;
    cfg(8'h04);
    wait_ticks(k + 16'h0004);
    r = readCount;
    chk(lastFlow === 16'h0106 + {k[13:0], 2'b00});
    chk(tempOut === 16'h1234 + (k + 16'h0003) / 16'h000A * 16'h000A);
    chk(statusOut === 16'h00A8 + k);
    wait_ticks(k + 16'h0008);
    chk(readCount === r + 16'h0001 && lastFlow === 16'h0116 + {k[13:0], 2'b00});
  endtask
  task automatic t_raw;
    cfg(8'h01);
    wait_ticks(k + 16'h0002);
    r = readCount;
    chk(lastFlow === 16'h0104 + {k[13:0], 2'b00});
    wait_ticks(k + 16'h0003);
    chk(readCount === r + 16'h0001);
    @(posedge core_clk) en <= 1'b0;
  endtask
  // Back to until-read, then an out-of-range N that must change nothing
  task automatic t_back;
    cfg(8'h00);
    r = k;
    cfg(8'h81);
    wait_ticks(r + 16'h0002);
    n = readCount;
    @(posedge core_clk) en <= 1'b1;
    while (readCount == n) @(negedge core_clk);
    chk(lastFlow === 16'h0102 + {r[13:0], 2'b00});
  endtask
  task automatic t_reset;
    @(posedge core_clk) softResetCmd <= 1'b1;
    @(posedge core_clk) softResetCmd <= 1'b0;
    @(negedge core_clk);
    chk(!heaterOn && !reading_ready_n && commReady === 1'b0);
    wait_ready(n);
    chk(n <= 63);
    @(posedge core_clk) scl <= 1'b0;
    @(posedge core_clk) wakeCmd <= 1'b1;
    @(posedge core_clk) wakeCmd <= 1'b0;
    @(negedge core_clk);
    wait_ready(n);
    chk(n > 62 && n <= 82);
    @(posedge core_clk) scl <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_boot();
    @(posedge core_clk) en <= 1'b0;
    t_until();
    t_fixed();
    t_raw();
    t_back();
    t_reset();
    finish_test();
  end
endmodule
bind fma_flow_avg fma_flow_avg_properties #(.SAMPLE_CYC(SAMPLE_CYC), .FIRST_CYC(FIRST_CYC),
  .READY_MAX_CYC(READY_MAX_CYC)) props (.core_clk, .nrst, .startCmd, .softResetCmd,
  .wakeCmd, .readReq, .readDone, .commReady, .heaterOn, .sampleTick, .readAck,
  .reading_ready_n);
